/* File: scs_pin_mux.sv */
// scs_pin_mux: serial clock and slave-select pin logic of the shared port
// assumes strobes and spi config are on clk; masterClockOut is on linkClk
`timescale 1ns/1ps

// Behaviour
// - direction write loads bits from bus; direction read returns stored bits
// - reset clears both direction bits, pins start as inputs
// - mode fault clears serial clock direction bit at once
// - mode fault is master configuration with slave select asserted
// - clock pin: disabled or master follows direction bit, slave forces input
// - clock pin data from master clock when enabled, else port latch
// - port write always loads output latches
// - port read returns driven value if driving, else buffered pin level
// - wired-or select: never drive high, a one leaves pin floating
// - buffered clock pin always feeds spi slave clock input
// - mode fault never clears slave-select direction bit
// - select pin: slave forces input, master or disabled follows direction
// - select pin data always from port latch
// - internal select is inverted pin, gated by enable and driver off
// - spi disabled holds internal select low
// - master with select direction one blocks internal select
// - mode fault also clears data-in and data-out direction bits
module scs_pin_mux
   import scs_pkg::*;
#(
   parameter int BUS_W = SCS_BUS_W
)
(
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             linkClk,
   input  wire logic [BUS_W-1:0] busWrData,
   output logic      [BUS_W-1:0] busRdData,
   input  wire logic             directionWriteStrobe,
   input  wire logic             directionReadStrobe,
   input  wire logic             portWriteStrobe,
   input  wire logic             portReadStrobe,
   input  wire logic             spiEnableBit,
   input  wire logic             masterSelectBit,
   input  wire logic             wiredOrSelect,
   input  wire logic             masterClockOut,
   input  wire logic             sckPinIn,
   output logic                  sckPinOut,
   output logic                  sckPinOe,
   input  wire logic             ssPinIn,
   output logic                  ssPinOut,
   output logic                  ssPinOe,
   output logic                  slaveClockIn,
   output logic                  slaveSelect,
   output logic                  modeFault,
   output logic                  dataPinDirClear
);

   // driver enable: only an enabled slave forces the pin to input
   function automatic logic drv_en(input logic dir, input scs_ctrl_t c);
      drv_en = dir & ~(c.spi_enable_bit & ~c.master_select_bit);
   endfunction

   // open drain: with wired-or a one releases the pin
   function automatic scs_pin_t pin_drive(input logic en, input logic d,
                                          input logic wom);
      scs_pin_t p;
      p.out = d & ~wom;
      p.oe  = en & ~(wom & d);
      pin_drive = p;
   endfunction

   scs_ctrl_t              ctrl;
   logic                   sckDir_reg;
   logic                   ssDir_reg;
   logic                   sckLat_reg;
   logic                   ssLat_reg;
   logic [SCS_SYNC_N-1:0]  sckSync_reg;
   logic [SCS_SYNC_N-1:0]  ssSync_reg;
   logic [SCS_SYNC_N-1:0]  sckBack_reg;
   logic                   sckLevel;
   logic                   ssLevel;
   logic                   sckBack;
   logic                   sckDrv;
   logic                   ssDrv;
   scs_pin_t               ssPin_next;
   scs_pin_t               ssPin_reg;
   logic                   selNext;
   logic                   slaveSel_reg;
   logic [BUS_W-1:0]       rd_next;
   logic [BUS_W-1:0]       rd_reg;
   scs_link_t              toLink;
   scs_link_t              linkMeta_reg;
   scs_link_t              linkSync_reg;
   scs_pin_t               sckPin_next;
   scs_pin_t               sckPin_reg;

   assign ctrl = '{spi_enable_bit: spiEnableBit, master_select_bit: masterSelectBit, wom: wiredOrSelect};

   // pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sckSync_reg <= '0;
         ssSync_reg  <= '1;
         sckBack_reg <= '0;
      end else begin
         sckSync_reg <= {sckSync_reg[0], sckPinIn};
         ssSync_reg  <= {ssSync_reg[0], ssPinIn};
         sckBack_reg <= {sckBack_reg[0], sckPin_reg.out};
      end
   end

   assign sckLevel = sckSync_reg[SCS_SYNC_N-1];
   assign ssLevel  = ssSync_reg[SCS_SYNC_N-1];
   assign sckBack  = sckBack_reg[SCS_SYNC_N-1];

   assign slaveClockIn = sckLevel;

   assign sckDrv = drv_en(sckDir_reg, ctrl);
   assign ssDrv  = drv_en(ssDir_reg, ctrl);

   assign selNext = ctrl.spi_enable_bit & ~ssDrv & ~ssLevel;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         slaveSel_reg <= 1'h0;
      end else begin
         slaveSel_reg <= selNext;
      end
   end

   assign slaveSelect = slaveSel_reg;

   assign modeFault       = slaveSel_reg & ctrl.spi_enable_bit & ctrl.master_select_bit;
   assign dataPinDirClear = modeFault;

   // direction bits; the fault clear of the clock bit overrides a same-cycle write
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sckDir_reg <= SCS_DIR_RST;
      end else if (modeFault) begin
         sckDir_reg <= SCS_DIR_RST;
      end else if (directionWriteStrobe) begin
         sckDir_reg <= busWrData[SCS_SCK_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ssDir_reg <= SCS_DIR_RST;
      end else if (directionWriteStrobe) begin
         ssDir_reg <= busWrData[SCS_SS_BIT];
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sckLat_reg <= SCS_LAT_RST;
         ssLat_reg  <= SCS_LAT_RST;
      end else if (portWriteStrobe) begin
         sckLat_reg <= busWrData[SCS_SCK_BIT];
         ssLat_reg  <= busWrData[SCS_SS_BIT];
      end
   end

   assign ssPin_next = pin_drive(ssDrv, ssLat_reg, ctrl.wom);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ssPin_reg <= '{out: SCS_PIN_RST, oe: 1'h0};
      end else begin
         ssPin_reg <= ssPin_next;
      end
   end

   assign ssPinOut = ssPin_reg.out;
   assign ssPinOe  = ssPin_reg.oe;

   // read mux; clock pin drive value returns through a synchroniser
   always_comb begin
      rd_next = '0;
      if (directionReadStrobe) begin
         rd_next[SCS_SCK_BIT] = sckDir_reg;
         rd_next[SCS_SS_BIT]  = ssDir_reg;
      end else if (portReadStrobe) begin
         rd_next[SCS_SCK_BIT] = sckDrv ? sckBack : sckLevel;
         rd_next[SCS_SS_BIT]  = ssDrv ? ssPin_next.out : ssLevel;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_reg <= '0;
      end else begin
         rd_reg <= rd_next;
      end
   end

   assign busRdData = rd_reg;

   // levels for the link domain
   assign toLink = '{dir: sckDir_reg, lat: sckLat_reg, ctrl: ctrl};

   // link domain: clock pin driven beside the master clock source
   always_ff @(posedge linkClk or negedge resetn) begin
      if (!resetn) begin
         linkMeta_reg <= '0;
         linkSync_reg <= '0;
      end else begin
         linkMeta_reg <= toLink;
         linkSync_reg <= linkMeta_reg;
      end
   end

   assign sckPin_next = pin_drive(drv_en(linkSync_reg.dir, linkSync_reg.ctrl),
                                  linkSync_reg.ctrl.spi_enable_bit ? masterClockOut
                                                        : linkSync_reg.lat,
                                  linkSync_reg.ctrl.wom);

   always_ff @(posedge linkClk or negedge resetn) begin
      if (!resetn) begin
         sckPin_reg <= '{out: SCS_PIN_RST, oe: 1'h0};
      end else begin
         sckPin_reg <= sckPin_next;
      end
   end

   assign sckPinOut = sckPin_reg.out;
   assign sckPinOe  = sckPin_reg.oe;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   property p_dir_write;
      directionWriteStrobe && !modeFault |=>
         sckDir_reg == $past(busWrData[SCS_SCK_BIT]) &&
         ssDir_reg == $past(busWrData[SCS_SS_BIT]);
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write not loaded");

   property p_dir_read;
      directionReadStrobe |=> busRdData[SCS_SS_BIT] == $past(ssDir_reg);
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("direction read wrong");

   property p_fault_clear;
      modeFault |=> !sckDir_reg && !sckDrv;
   endproperty
   a_fault_clear: assert property (p_fault_clear)
      else $error("fault did not clear clock direction");

   property p_fault_cause;
      spiEnableBit && masterSelectBit && !ssDir_reg && !ssLevel
         ##1 spiEnableBit && masterSelectBit |-> modeFault;
   endproperty
   a_fault_cause: assert property (p_fault_cause)
      else $error("mode fault missed");

   property p_ss_keep;
      modeFault && !directionWriteStrobe |=> $stable(ssDir_reg);
   endproperty
   a_ss_keep: assert property (p_ss_keep)
      else $error("select direction changed by fault");

   property p_port_write;
      portWriteStrobe |=> ssLat_reg == $past(busWrData[SCS_SS_BIT]) &&
         sckLat_reg == $past(busWrData[SCS_SCK_BIT]);
   endproperty
   a_port_write: assert property (p_port_write)
      else $error("port latch not loaded");

   property p_sel_off;
      !spiEnableBit || (masterSelectBit && ssDir_reg) |=> !slaveSelect;
   endproperty
   a_sel_off: assert property (p_sel_off)
      else $error("internal select not blocked");

   property p_ss_slave;
      spiEnableBit && !masterSelectBit |=> !ssPinOe;
   endproperty
   a_ss_slave: assert property (p_ss_slave)
      else $error("select pin driven in slave mode");

   property p_ss_wom;
      ssPinOe && wiredOrSelect ##0 $past(wiredOrSelect) |-> !ssPinOut;
   endproperty
   a_ss_wom: assert property (p_ss_wom)
      else $error("select pin driven high under wired-or");

   property p_rd_pin;
      portReadStrobe && !directionReadStrobe && !ssDrv |=>
         busRdData[SCS_SS_BIT] == $past(ssLevel);
   endproperty
   a_rd_pin: assert property (p_rd_pin)
      else $error("port read source wrong");

   property p_sck_data;
      @(posedge linkClk) disable iff (!resetn)
         linkSync_reg.ctrl.spi_enable_bit && sckPin_next.oe && !linkSync_reg.ctrl.wom
         |=> sckPinOut == $past(masterClockOut);
   endproperty
   a_sck_data: assert property (p_sck_data)
      else $error("clock pin data not from master clock");

   c_fault:   cover property (modeFault);
   c_ss_gpo:  cover property (spiEnableBit && masterSelectBit && ssPinOe);
   c_sck_drv: cover property (@(posedge linkClk) sckPinOe && sckPinOut);

endmodule

/* File: scs_pin_mux_bench.sv */
// scs_pin_mux_bench: self-checking bench for the clock and select pin mux
// assumes the peer model with pull-ups and a free running link clock
`timescale 1ns/1ps
module scs_pin_mux_bench;
   import scs_pkg::*;
   logic       clk, linkClk, resetn, spi_enable_bit, master_select_bit, wom, mClk, mClkReq;
   logic       dirWr, dirRd, portWr, portRd;
   logic [7:0] wrData, rdData;
   logic       sckIn, sckOut, sckOe, ssIn, ssOut, ssOe;
   logic       slvClk, slvSel, mFault, dClr, peerSckOe, peerSck, peerSsLow;
   int         n_fail, n_checks;

   scs_pin_mux u_dut (.clk(clk), .resetn(resetn), .linkClk(linkClk), .busWrData(wrData),
      .busRdData(rdData), .directionWriteStrobe(dirWr), .directionReadStrobe(dirRd),
      .portWriteStrobe(portWr), .portReadStrobe(portRd), .spiEnableBit(spi_enable_bit),
      .masterSelectBit(master_select_bit), .wiredOrSelect(wom), .masterClockOut(mClk),
      .sckPinIn(sckIn), .sckPinOut(sckOut), .sckPinOe(sckOe), .ssPinIn(ssIn),
      .ssPinOut(ssOut), .ssPinOe(ssOe), .slaveClockIn(slvClk), .slaveSelect(slvSel),
      .modeFault(mFault), .dataPinDirClear(dClr));

   scs_spi_peer u_peer (.sckDrv({sckOut, sckOe}), .ssDrv({ssOut, ssOe}),
      .peerSckOe(peerSckOe), .peerSck(peerSck), .peerSsLow(peerSsLow),
      .sckLine(sckIn), .ssLine(ssIn));

   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // odd offset keeps the link clock out of phase with clk
   initial begin
      linkClk = 1'h0;
      #7;
      forever #24 linkClk = ~linkClk;
   end
   always @(negedge linkClk) mClk <= mClkReq;

   task automatic report_and_stop;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // one strobe pulse; read data stands at the negedge after the taking edge
   task automatic strobe(input int kind, input logic [7:0] d);
      @(negedge clk);
      wrData = d;
      case (kind)
         0: dirWr = 1'h1;
         1: dirRd = 1'h1;
         2: portWr = 1'h1;
         default: portRd = 1'h1;
      endcase
      @(negedge clk);
      {dirWr, dirRd, portWr, portRd} = 4'h0;
   endtask

   // link side needs sync plus output flop; generous fixed settle
   task automatic settle;
      repeat (150) @(negedge clk);
   endtask

   task automatic t_reset;
      chk({sckOe, ssOe}, 8'h00, "pins after reset");
      strobe(1, 8'h00);
      chk(rdData, 8'h00, "dir after reset");
   endtask

   task automatic t_disabled;
      strobe(0, 8'h30);
      strobe(1, 8'h00);
      chk(rdData, 8'h30, "dir readback");
      strobe(2, 8'h20);
      settle;
      chk({ssOe, ssOut, sckOe, sckOut}, 8'h0e, "disabled drive");
      strobe(3, 8'h00);
      chk(rdData, 8'h20, "driven readback");
      strobe(0, 8'h00);
      peerSsLow = 1'h1;
      settle;
      chk(slvSel, 8'h00, "select while off");
      strobe(3, 8'h00);
      chk(rdData, 8'h10, "pin readback");
      peerSsLow = 1'h0;
   endtask

   task automatic t_wired;
      wom = 1'h1;
      strobe(0, 8'h30);
      strobe(2, 8'h30);
      settle;
      chk({sckOe, ssOe}, 8'h00, "wired-or one floats");
      strobe(2, 8'h00);
      settle;
      chk({sckOe, sckOut, ssOe, ssOut}, 8'h0a, "wired-or zero drives");
      wom = 1'h0;
   endtask

   task automatic t_master;
      spi_enable_bit = 1'h1;
      master_select_bit = 1'h1;
      mClkReq = 1'h1;
      settle;
      chk({ssOe, ssOut, sckOe, sckOut, slvClk}, 8'h17, "master clock out");
      chk({slvSel, mFault}, 8'h00, "select blocked");
      mClkReq = 1'h0;
      settle;
      chk({sckOut, slvClk}, 8'h00, "master clock low");
   endtask

   task automatic t_slave;
      master_select_bit = 1'h0;
      peerSckOe = 1'h1;
      peerSck = 1'h1;
      settle;
      chk({sckOe, ssOe, slvClk}, 8'h01, "slave pins");
      peerSsLow = 1'h1;
      settle;
      chk({slvSel, mFault}, 8'h02, "slave selected");
      peerSsLow = 1'h0;
      peerSckOe = 1'h0;
   endtask

   task automatic t_fault;
      // stay slave while the select line resyncs high; a stale low would fault
      strobe(0, 8'h10);
      strobe(1, 8'h00);
      chk(rdData, 8'h10, "clock dir set");
      master_select_bit = 1'h1;
      settle;
      chk(sckOe, 8'h01, "master clock drive");
      peerSsLow = 1'h1;
      settle;
      chk({mFault, dClr, slvSel, sckOe}, 8'h0e, "mode fault");
      strobe(1, 8'h00);
      chk(rdData, 8'h00, "fault cleared dir");
      // write lands while the fault is still up: clock bit refused
      strobe(0, 8'h30);
      strobe(1, 8'h00);
      chk(rdData, 8'h20, "select dir kept");
      peerSsLow = 1'h0;
   endtask

   initial begin
      {resetn, spi_enable_bit, master_select_bit, wom, mClkReq} = 5'h00;
      {dirWr, dirRd, portWr, portRd, peerSckOe, peerSck, peerSsLow} = 7'h00;
      wrData = 8'h00;
      n_fail = 0;
      n_checks = 0;
      repeat (6) @(negedge clk);
      resetn = 1'h1;
      t_reset;
      t_disabled;
      t_wired;
      t_master;
      t_slave;
      t_fault;
      report_and_stop;
   end

   // whole run is about 1540 clk cycles; allow well over that
   initial begin
      #100000;
      n_fail++;
      report_and_stop;
   end
endmodule

/* File: scs_pkg.sv */
// scs_pkg: constants and carrier types for the clock and select pin mux
// assumes a byte-wide internal bus and pins on the shared port

package scs_pkg;

   // internal bus width and pin bit positions on the port
   localparam int          SCS_BUS_W    = 8;
   localparam int          SCS_SCK_BIT  = 4;
   localparam int          SCS_SS_BIT   = 5;

   // reset values
   localparam logic        SCS_DIR_RST  = 1'h0;
   localparam logic        SCS_LAT_RST  = 1'h0;
   localparam logic        SCS_PIN_RST  = 1'h0;

   // synchroniser depth for pins and crossings
   localparam int          SCS_SYNC_N   = 2;

   // spi configuration bits seen by the pins
   typedef struct packed {
      logic spi_enable_bit;
      logic master_select_bit;
      logic wom;
   } scs_ctrl_t;

   // levels carried into the link clock domain
   typedef struct packed {
      logic      dir;
      logic      lat;
      scs_ctrl_t ctrl;
   } scs_link_t;

   // one open-drain capable pin output
   typedef struct packed {
      logic out;
      logic oe;
   } scs_pin_t;

endpackage

/* File: scs_spi_peer.sv */
// scs_spi_peer: far-side spi device sharing the clock and select lines
// assumes pull-ups on both lines; the bench steers what the peer drives
`timescale 1ns/1ps
module scs_spi_peer
   import scs_pkg::*;
(
   input  wire scs_pin_t sckDrv,
   input  wire scs_pin_t ssDrv,
   input  wire logic     peerSckOe,
   input  wire logic     peerSck,
   input  wire logic     peerSsLow,
   output logic          sckLine,
   output logic          ssLine
);
   // released lines float to the pull-up level, never the last value
   assign sckLine = sckDrv.oe ? sckDrv.out : (peerSckOe ? peerSck : 1'h1);
   // a peer only ever pulls select low, as a master addressing us would
   assign ssLine  = ssDrv.oe ? ssDrv.out : (peerSsLow ? 1'h0 : 1'h1);
endmodule
